/* File: spsc_top.sv */
// Chosen here: the APB slave port.
`include "spsc_consts.svh"

module spsc_top import spsc_pkg::*; (
	input wire logic pclk, // bus clock, 10 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB write strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic sclk_in, // serial clock pin level
	output logic sclk_out, // serial clock pin drive value
	output logic sclk_oe, // serial clock pin drive enable
	input wire logic mosi_in, // master-out pin level
	output logic mosi_out, // master-out pin drive value
	output logic mosi_oe, // master-out pin drive enable
	input wire logic miso_in, // master-in pin level
	output logic miso_out, // master-in pin drive value
	output logic miso_oe, // master-in pin drive enable
	input wire logic ss_n_in, // slave select pin, active low
	output logic ss_gpio_release, // select pin handed to port logic
	output logic irq // interrupt request, active high
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
			prev <= 4'hf;
		end else begin
			sync1 <= {ss_n_in, miso_in, mosi_in, sclk_in};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	wire sclk_s = sync2[0];
	wire mosi_s = sync2[1];
	wire miso_s = sync2[2];
	wire ss_s = sync2[3];
	wire ss_fall = prev[3] & ~ss_s;
	wire ss_rise = ~prev[3] & ss_s;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl;
	logic error_interrupt_enable;
	logic mode_fault_enable;
	logic [1:0] rate;
	logic rf;
	logic ovr;
	logic mode_fault_flag;
	logic te;
	logic ovr_arm;
	logic mode_fault_flag_arm;
	logic [7:0] txbuf;
	logic [7:0] rxbuf;
	spsc_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] div_cnt;
	logic half_odd;
	logic sclk_lvl;
	logic out_bit;
	logic sample_bit;

	wire rie = ctrl[`SPSC_C_RIE];
	wire mstr = ctrl[`SPSC_C_MSTR];
	wire clock_idle_polarity = ctrl[`SPSC_C_CLOCK_IDLE_POLARITY];
	wire clock_phase_select = ctrl[`SPSC_C_CLOCK_PHASE_SELECT];
	wire wom = ctrl[`SPSC_C_WOM];
	wire interface_enable = ctrl[`SPSC_C_SPE];
	wire tie = ctrl[`SPSC_C_TIE];
	wire active = (state == SPSC_ACTIVE);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite & pstrb[0];
	wire rd = acc & ~pwrite;
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_ctrl = aligned & (paddr[7:2] == `SPSC_IDX_CTRL);
	wire hit_stat = aligned & (paddr[7:2] == `SPSC_IDX_STAT);
	wire hit_data = aligned & (paddr[7:2] == `SPSC_IDX_DATA);
	wire hit_pin = aligned & (paddr[7:2] == `SPSC_IDX_PIN);
	wire mapped = hit_ctrl | hit_stat | hit_data | hit_pin;
	wire [7:0] stat_rd = {rf, error_interrupt_enable, ovr, mode_fault_flag, te, mode_fault_enable, rate};
	wire [7:0] read_mux = hit_ctrl ? (ctrl & `SPSC_CTRL_MASK) :
		hit_stat ? stat_rd :
		hit_data ? rxbuf :
		hit_pin ? {7'h00, ss_s} : 8'h00;
	wire data_rd = rd & hit_data;
	wire data_wr = wr & hit_data;
	wire stat_rd_acc = rd & hit_stat;

	// One wait state: pready rises in the second access cycle so read data comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			prdata <= {24'h00_0000, read_mux};
			pslverr <= psel & penable & ~pready & ~mapped;
		end
	end

	// ----------------------------------------
	// Master clock generator
	// ----------------------------------------
	wire [7:0] bd = (rate == 2'd0) ? `SPSC_BD_0 :
		(rate == 2'd1) ? `SPSC_BD_1 :
		(rate == 2'd2) ? `SPSC_BD_2 : `SPSC_BD_3;
	wire is_master = interface_enable & mstr;
	wire is_slave = interface_enable & ~mstr;
	wire gen_edge = is_master & active & (div_cnt == bd - 8'd1);
	wire m_lead = gen_edge & ~half_odd;
	wire m_trail = gen_edge & half_odd;

	// ----------------------------------------
	// Slave edge detection
	// ----------------------------------------
	// A deselected slave sees no clock edges at all, but its state is left as it was.
	wire s_chg = is_slave & ~ss_s & (sclk_s != prev[0]);
	wire s_lead = s_chg & (sclk_s != clock_idle_polarity);
	wire s_trail = s_chg & (sclk_s == clock_idle_polarity);
	wire s_start = is_slave & ~active & (clock_phase_select ? s_lead : (ss_fall & ~ss_s));
	wire lead = m_lead | (s_lead & (active | s_start));
	wire trail = m_trail | (s_trail & active);
	wire din = mstr ? miso_s : mosi_s;

	// ----------------------------------------
	// Shift register hookup
	// ----------------------------------------
	spsc_shift_if #(.W(8)) sif ();

	spsc_shifter #(.W(8)) u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.sif(sif)
	);

	// Loading only in idle keeps a running slave byte intact; later writes wait in txbuf.
	wire do_load = interface_enable & ~active & ~te;
	wire shift_in = clock_phase_select ? din : sample_bit;
	wire done = trail & (bit_cnt == 3'd7);
	wire [7:0] rx_word = {sif.word[6:0], shift_in};
	wire m_start = is_master & do_load;

	assign sif.load = do_load;
	assign sif.load_data = txbuf;
	assign sif.shift = trail & ~do_load;
	assign sif.shift_in = shift_in;

	// ----------------------------------------
	// Control and configuration bits
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `SPSC_CTRL_RST;
			error_interrupt_enable <= 1'b0;
			mode_fault_enable <= 1'b0;
			rate <= 2'b00;
		end else if (wr & hit_ctrl) begin
			ctrl <= pwdata[7:0] & `SPSC_CTRL_MASK;
		end else if (wr & hit_stat) begin
			error_interrupt_enable <= pwdata[`SPSC_S_ERROR_INTERRUPT_ENABLE];
			mode_fault_enable <= pwdata[`SPSC_S_MODE_FAULT_ENABLE];
			rate <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Buffers and flags
	// ----------------------------------------
	wire mode_fault_flag_set = interface_enable & mode_fault_enable & (mstr ? ~ss_s : (active & ss_rise));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txbuf <= 8'h00;
			rxbuf <= 8'h00;
			te <= 1'b1;
			rf <= 1'b0;
			ovr <= 1'b0;
			mode_fault_flag <= 1'b0;
			ovr_arm <= 1'b0;
			mode_fault_flag_arm <= 1'b0;
		end else begin
			if (data_wr) txbuf <= pwdata[7:0];
			if (data_wr) te <= 1'b0;
			if (do_load) te <= 1'b1;
			if (stat_rd_acc) ovr_arm <= ovr;
			if (stat_rd_acc) mode_fault_flag_arm <= mode_fault_flag;
			if (data_rd) rf <= 1'b0;
			if (data_rd & ovr_arm) ovr <= 1'b0;
			if (data_rd) ovr_arm <= 1'b0;
			if (data_wr & mode_fault_flag_arm) mode_fault_flag <= 1'b0;
			if (data_wr) mode_fault_flag_arm <= 1'b0;
			// Setting wins over a clear in the same cycle.
			if (done & ~rf) rxbuf <= rx_word;
			if (done & ~rf) rf <= 1'b1;
			if (done & rf) ovr <= 1'b1;
			if (mode_fault_flag_set) mode_fault_flag <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SPSC_IDLE;
			bit_cnt <= 3'd0;
			div_cnt <= 8'd0;
			half_odd <= 1'b0;
			sclk_lvl <= 1'b0;
			out_bit <= 1'b0;
			sample_bit <= 1'b0;
		end else if (!interface_enable) begin
			state <= SPSC_IDLE;
			bit_cnt <= 3'd0;
			div_cnt <= 8'd0;
			half_odd <= 1'b0;
			sclk_lvl <= clock_idle_polarity;
		end else begin
			if (!active) sclk_lvl <= clock_idle_polarity;
			if (m_start) begin
				state <= SPSC_ACTIVE;
				out_bit <= txbuf[7];
			end
			if (s_start) begin
				state <= SPSC_ACTIVE;
				out_bit <= sif.word[7];
			end
			if (is_master & active) begin
				div_cnt <= gen_edge ? 8'd0 : div_cnt + 8'd1;
			end
			if (gen_edge) begin
				half_odd <= ~half_odd;
				sclk_lvl <= ~sclk_lvl;
			end
			if (lead) begin
				sample_bit <= din;
				if (clock_phase_select) out_bit <= sif.word[7];
			end
			if (trail) begin
				bit_cnt <= bit_cnt + 3'd1;
				if (!clock_phase_select) out_bit <= sif.word[6];
			end
			if (done) begin
				state <= SPSC_IDLE;
				bit_cnt <= 3'd0;
			end
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// In wired-OR mode a pin is only ever pulled low; a one is left to the external pullup.
	wire sclk_val = mstr & active ? sclk_lvl : clock_idle_polarity;
	wire next_sclk_oe = is_master & (~wom | ~sclk_val);
	wire next_sclk_out = ~wom & sclk_val;
	wire next_mosi_oe = is_master & (~wom | ~out_bit);
	wire next_mosi_out = ~wom & out_bit;
	wire next_miso_oe = is_slave & ~ss_s & (~wom | ~out_bit);
	wire next_miso_out = ~wom & out_bit;
	wire next_release = ~interface_enable | (mstr & ~mode_fault_enable);
	wire next_irq = (rf & rie) | (te & tie) | ((mode_fault_flag | ovr) & error_interrupt_enable);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_oe <= 1'b0;
			sclk_out <= 1'b0;
			mosi_oe <= 1'b0;
			mosi_out <= 1'b0;
			miso_oe <= 1'b0;
			miso_out <= 1'b0;
			ss_gpio_release <= 1'b1;
			irq <= 1'b0;
		end else begin
			sclk_oe <= next_sclk_oe;
			sclk_out <= next_sclk_out;
			mosi_oe <= next_mosi_oe;
			mosi_out <= next_mosi_out;
			miso_oe <= next_miso_oe;
			miso_out <= next_miso_out;
			ss_gpio_release <= next_release;
			irq <= next_irq;
		end
	end
endmodule : spsc_top

/* File: spsc_consts.svh */
`ifndef SPSC_CONSTS_SVH
`define SPSC_CONSTS_SVH

// ----------------------------------------
// Register indexes (byte address is the index times four)
// ----------------------------------------
`define SPSC_IDX_CTRL 6'h10
`define SPSC_IDX_STAT 6'h11
`define SPSC_IDX_DATA 6'h12
`define SPSC_IDX_PIN 6'h13

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SPSC_C_RIE 7
`define SPSC_C_MSTR 5
`define SPSC_C_CLOCK_IDLE_POLARITY 4
`define SPSC_C_CLOCK_PHASE_SELECT 3
`define SPSC_C_WOM 2
`define SPSC_C_SPE 1
`define SPSC_C_TIE 0
`define SPSC_CTRL_MASK 8'hbf
`define SPSC_CTRL_RST 8'h28
`define SPSC_S_RF 7
`define SPSC_S_ERROR_INTERRUPT_ENABLE 6
`define SPSC_S_OVR 5
`define SPSC_S_MODE_FAULT_FLAG 4
`define SPSC_S_TE 3
`define SPSC_S_MODE_FAULT_ENABLE 2
`define SPSC_STAT_RST 8'h08

// ----------------------------------------
// Half-period counts of the master clock
// ----------------------------------------
`define SPSC_BD_0 8'd2
`define SPSC_BD_1 8'd8
`define SPSC_BD_2 8'd32
`define SPSC_BD_3 8'd128
`endif

/* File: spsc_pkg.sv */
package spsc_pkg;
	typedef enum logic {SPSC_IDLE, SPSC_ACTIVE} spsc_state_t;
endpackage : spsc_pkg

/* File: spsc_shift_if.sv */
interface spsc_shift_if #(parameter int W = 8);
	logic load;
	logic [W-1:0] load_data;
	logic shift;
	logic shift_in;
	logic [W-1:0] word;
	modport ctl (output load, output load_data, output shift, output shift_in, input word);
	modport sh (input load, input load_data, input shift, input shift_in, output word);
endinterface : spsc_shift_if

/* File: spsc_shifter.sv */
module spsc_shifter #(
	parameter int W = 8
) (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	spsc_shift_if.sh sif // shift control and word
);
	if (W < 2) begin : g_bad_width
		$error("spsc_shifter: W must be at least 2");
	end

	logic [W-1:0] sreg;

	// Load takes precedence; the controller never asks for both at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sreg <= '0;
		else if (sif.load) sreg <= sif.load_data;
		else if (sif.shift) sreg <= {sreg[W-2:0], sif.shift_in};
	end

	assign sif.word = sreg;
endmodule : spsc_shifter

/* File: spsc_asserts.sv */
module spsc_asserts (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // bus select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [3:0] pstrb, // write strobes
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic sclk_out, // clock drive value
	input wire logic mosi_out, // master-out drive value
	input wire logic miso_out, // master-in drive value
	input wire logic miso_oe, // master-in drive enable
	input wire logic ss_n_in, // select pin level
	input wire logic ss_gpio_release // select pin freed
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] ctrl_q;
	logic [2:0] stat_q;
	wire wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
	// Shadow copies let the checker know the mode without seeing inside the block.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 8'h28;
			stat_q <= 3'h0;
		end else begin
			if (wr_ok && paddr == 8'h40) ctrl_q <= pwdata[7:0];
			if (wr_ok && paddr == 8'h44) stat_q <= pwdata[2:0];
		end
	end
	wire mst_fast = ctrl_q[1] && ctrl_q[5] && !ctrl_q[4] && !ctrl_q[2] && stat_q[1:0] == 2'h1;
	// Rate code 1 gives a half period of eight bus cycles.
	sequence half_hi;
		sclk_out [*8] ##1 !sclk_out;
	endsequence
	miso_off_a: assert property (ss_n_in [*5] |-> !miso_oe)
		else $error("master-in driven while deselected");
	slave_pin_a: assert property ((ctrl_q[1] && !ctrl_q[5]) [*2] |-> !ss_gpio_release)
		else $error("select pin freed in slave mode");
	master_pin_a: assert property ((ctrl_q[1] && ctrl_q[5]) [*2] |-> ss_gpio_release == !$past(stat_q[2]))
		else $error("select pin ownership wrong in master mode");
	rate_half_a: assert property (mst_fast && $rose(sclk_out) |-> half_hi)
		else $error("serial clock half period wrong");
	wired_or_a: assert property (ctrl_q[2] [*2] |-> !(sclk_out || mosi_out || miso_out))
		else $error("open-drain pin drives high");
	ready_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ready not after one wait");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	rdata_clean_a: assert property (pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
		else $error("read data upper bits or error data wrong");
endmodule : spsc_asserts

/* File: spsc_peer.sv */
module spsc_peer (
	input wire logic miso // master-in line level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclk = 1'b0;
	logic mosi = 1'b1;
	logic ss_n = 1'b1;
	logic [7:0] rx = 8'h00;
	// Callers pass the same phase as the device and polarity is always low.
	// With cut set, select rises mid-byte and a stray clock pulse is sent while deselected.
	task automatic xfer(input logic [7:0] tx, input logic clock_phase_select, input logic cut);
		#13 ss_n = 1'b0;
		mosi = tx[7];
		#800;
		for (int i = 7; i >= 0; i--) begin
			if (cut && i == 3) begin
				ss_n = 1'b1;
				#400 sclk = 1'b1;
				#400 sclk = 1'b0;
				#400 ss_n = 1'b0;
				#800;
			end
			if (clock_phase_select) mosi = tx[i];
			sclk = 1'b1;
			if (!clock_phase_select) rx = {rx[6:0], miso};
			#400 sclk = 1'b0;
			if (clock_phase_select) rx = {rx[6:0], miso};
			else if (i > 0) mosi = tx[i-1];
			#400;
		end
		// Select goes high between bytes; a released line must not keep its last bit.
		ss_n = 1'b1;
		mosi = ~mosi;
	endtask : xfer
endmodule : spsc_peer

/* File: testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, e, miso_w;
	logic [7:0] paddr, r;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_gpio_release, irq;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	// An undriven master-in line rests high on its pull-up; in master mode it loops back from master-out.
	assign miso_w = miso_oe ? miso_out : (mosi_oe ? mosi_out : 1'b1);
	spsc_peer u_peer(.miso(miso_w));
	spsc_top u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclk_in(sclk_oe ? sclk_out : u_peer.sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.mosi_in(mosi_oe ? mosi_out : u_peer.mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(u_peer.ss_n),
		.ss_gpio_release(ss_gpio_release), .irq(irq));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task t_reset;
		apb(0, 8'h40, 0); chk("ctrl", r, 8'h28);
		apb(0, 8'h44, 0); chk("stat", r, 8'h08);
		apb(0, 8'h50, 0); chk("unmapped", {7'h0, e}, 8'h01);
		apb(0, 8'h4c, 0); chk("pin_high", r, 8'h01);
		apb(1, 8'h44, 8'hff);
		apb(0, 8'h44, 0); chk("stat_ro", r, 8'h4f);
		apb(1, 8'h44, 8'h00);
		chk("irq_idle", {7'h0, irq}, 8'h00);
	endtask : t_reset
	task t_slave;
		apb(1, 8'h40, 8'h82);
		apb(1, 8'h48, 8'ha5); // loaded before select falls
		apb(0, 8'h44, 0); chk("te_load", r, 8'h08);
		fork
			u_peer.xfer(8'h3c, 1'b0, 1'b0);
			begin
				repeat (20) @(posedge pclk);
				apb(1, 8'h48, 8'h5a);
			end
		join
		repeat (8) @(posedge pclk);
		chk("tx0", u_peer.rx, 8'ha5);
		chk("irq_rx", {7'h0, irq}, 8'h01);
		apb(0, 8'h48, 0); chk("rx0", r, 8'h3c);
		u_peer.xfer(8'h00, 1'b0, 1'b0);
		repeat (8) @(posedge pclk);
		chk("tx1", u_peer.rx, 8'h5a);
		chk("miso_off", {7'h0, miso_oe}, 8'h00);
		apb(0, 8'h48, 0);
		apb(1, 8'h40, 8'h8a);
		apb(1, 8'h48, 8'h96);
		u_peer.xfer(8'h69, 1'b1, 1'b0);
		repeat (8) @(posedge pclk);
		chk("tx_ph1", u_peer.rx, 8'h96);
		apb(0, 8'h48, 0); chk("rx_ph1", r, 8'h69);
		apb(1, 8'h44, 8'h04);
		apb(1, 8'h48, 8'hb4);
		u_peer.xfer(8'h4b, 1'b1, 1'b1);
		repeat (8) @(posedge pclk);
		chk("tx_cut", u_peer.rx, 8'hb4);
		apb(0, 8'h44, 0); chk("cut_fault", r, 8'h9c);
		apb(0, 8'h48, 0); chk("rx_cut", r, 8'h4b);
		apb(1, 8'h44, 8'h00);
		apb(1, 8'h48, 8'h00);
	endtask : t_slave
	task xm(input logic [7:0] d);
		apb(1, 8'h48, d);
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
		chk("irq_done", {7'h0, irq}, 8'h01);
		apb(0, 8'h48, 0); chk("loop", r, d);
	endtask : xm
	task t_master;
		apb(1, 8'h40, 8'ha2);
		repeat (2) @(posedge pclk);
		chk("free", {7'h0, ss_gpio_release}, 8'h01);
		u_peer.ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(0, 8'h4c, 0); chk("pin_low", r, 8'h00);
		apb(0, 8'h44, 0); chk("no_fault", r, 8'h08);
		apb(1, 8'h44, 8'h04);
		apb(0, 8'h44, 0); chk("fault", r, 8'h1c);
		chk("held", {7'h0, ss_gpio_release}, 8'h00);
		u_peer.ss_n <= 1'b1;
		// Rate code 1 leaves room for the pin synchroniser delay in the loopback path.
		apb(1, 8'h44, 8'h01);
		xm(8'hc3);
		apb(1, 8'h40, 8'ha6);
		xm(8'h0f);
	endtask : t_master
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_slave();
		t_master();
		end_sim();
	end
endmodule : testbench

bind spsc_top spsc_asserts u_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sclk_out(sclk_out), .mosi_out(mosi_out), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
	.ss_gpio_release(ss_gpio_release));
